// File: verilog/dual_8bit_interval_timer.v
// two 8-bit interval timer channels with port 3 direction and output control
//
// Summary of operation
// R1: software stops timers before writing output control
// R2: level set and clear bits read zero
// R3: direction bit 0 output, 1 input
// R4: reset loads direction register with all ones
// R5: software clears direction and latch for outputs
// R6: direction register takes bit and byte writes
// R7: each channel repeats its match interrupt
// R8: on match count clears, counting continues, interrupt
// R9: low clock select nibble picks channel 1 clock
// R10: high nibble picks channel 2 clock, same encoding
// R11: interval is compare plus one count periods
// R12: code 0110 gives 2 or 4 clocks, doubling
// R13: code 1111 gives 2^11 or 2^12 clocks
// R14: codes 0000 and 0001 count event pin edges
// R15: software writes only permitted clock codes
// R16: software stops timers before changing clock select
// R17: clearing run bit stops and zeroes count
// R18: osc mode comes from bit 0 of its register
//
// Our own choice: strobed register access.
`timescale 1ns/1ps

`include "interval_timer_consts.vh"

module dual_8bit_interval_timer #(
  parameter W = 8
) (
  input  wire                    clock,
  input  wire                    rst,
  input  wire [15:0]             reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire [7:0]              reg_wmask,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  input  wire [7:0]              port3_in,
  output reg  [7:0]              port3_out,
  output reg  [7:0]              port3_oe_n,
  output reg                     irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [7:0]             port3_direction_q;
  reg  [7:0]             port3_latch_q;
  reg  [W-1:0]           ch1_compare_q;
  reg  [W-1:0]           ch2_compare_q;
  reg  [7:0]             mode_ctrl_q;
  reg  [7:0]             count_clock_select_q;
  reg  [7:0]             output_ctrl_q;
  reg  [7:0]             osc_mode_q;
  reg  [7:0]             irq_status_q;
  reg  [7:0]             irq_mask_q;
  reg                    ch1_level_q;
  reg                    ch2_level_q;
  reg  [`PRESCALE_W-1:0] prescale_q;

  wire [W-1:0]           ch1_count;
  wire [W-1:0]           ch2_count;
  wire                   ch1_match_irq;
  wire                   ch2_match_irq;
  wire                   osc_mode_bit;
  wire                   ch1_run_enable;
  wire                   ch2_run_enable;

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  wire wr_dir     = reg_wr && (reg_addr == `ADDR_PORT3_DIRECTION);
  wire wr_latch   = reg_wr && (reg_addr == `ADDR_PORT3_LATCH);
  wire wr_cmp1    = reg_wr && (reg_addr == `ADDR_CH1_COMPARE);
  wire wr_cmp2    = reg_wr && (reg_addr == `ADDR_CH2_COMPARE);
  wire wr_mode    = reg_wr && (reg_addr == `ADDR_MODE_CTRL);
  wire wr_clksel  = reg_wr && (reg_addr == `ADDR_CLOCK_SELECT);
  wire wr_outctl  = reg_wr && (reg_addr == `ADDR_OUTPUT_CTRL);
  wire wr_osc     = reg_wr && (reg_addr == `ADDR_OSC_MODE);
  wire wr_status  = reg_wr && (reg_addr == `ADDR_IRQ_STATUS);
  wire wr_irqmask = reg_wr && (reg_addr == `ADDR_IRQ_MASK);

  // merge of written bits into a stored byte; a one-hot mask is a bit write
  function [7:0] merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask_v;
    begin
      merge = (old_v & ~mask_v) | (new_v & mask_v);
    end
  endfunction

  // written bits of the output control byte that take effect
  wire [7:0] outctl_new = merge(output_ctrl_q, reg_wdata, reg_wmask);

  assign osc_mode_bit   = osc_mode_q[`OSC_MODE_BIT]; // R18
  assign ch1_run_enable = mode_ctrl_q[`MODE_CH1_RUN];
  assign ch2_run_enable = mode_ctrl_q[`MODE_CH2_RUN];

  // ----------------------------------------------------------------------
  // shared prescaler
  // ----------------------------------------------------------------------
  // free running so both channels see the same phase; a channel that is
  // started mid-way may see its first internal tick early by up to one period
  always @(posedge clock) begin
    if (rst) begin
      prescale_q <= {`PRESCALE_W{1'b0}};
    end else begin
      prescale_q <= prescale_q + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  interval_channel #(
    .W          (W)
  ) u_ch1 (
    .clock      (clock),
    .rst        (rst),
    .run        (ch1_run_enable),
    .code       (count_clock_select_q[3:0]), // R9
    .osc_mode   (osc_mode_bit),
    .prescale_q (prescale_q),
    .event_in   (port3_in[`PIN_CH1_EVENT]),
    .compare    (ch1_compare_q),
    .count_q    (ch1_count),
    .match_q    (ch1_match_irq)
  );

  interval_channel #(
    .W          (W)
  ) u_ch2 (
    .clock      (clock),
    .rst        (rst),
    .run        (ch2_run_enable),
    .code       (count_clock_select_q[7:4]), // R10
    .osc_mode   (osc_mode_bit),
    .prescale_q (prescale_q),
    .event_in   (port3_in[`PIN_CH2_EVENT]),
    .compare    (ch2_compare_q),
    .count_q    (ch2_count),
    .match_q    (ch2_match_irq)
  );

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // clock select and output control are taken as written; software must
  // stop the channels first, a change while counting glitches the period
  always @(posedge clock) begin
    if (rst) begin
      port3_direction_q    <= `RST_PORT3_DIRECTION; // R4
      port3_latch_q        <= `RST_PORT3_LATCH;
      ch1_compare_q        <= `RST_COMPARE;
      ch2_compare_q        <= `RST_COMPARE;
      mode_ctrl_q          <= `RST_MODE_CTRL;
      count_clock_select_q <= `RST_CLOCK_SELECT;
      output_ctrl_q        <= `RST_OUTPUT_CTRL;
      osc_mode_q           <= `RST_OSC_MODE;
      irq_mask_q           <= `RST_IRQ_MASK;
    end else begin
      if (wr_dir) begin
        port3_direction_q <= merge(port3_direction_q, reg_wdata, reg_wmask); // R6
      end
      if (wr_latch) begin
        port3_latch_q <= merge(port3_latch_q, reg_wdata, reg_wmask);
      end
      if (wr_cmp1) begin
        ch1_compare_q <= merge(ch1_compare_q, reg_wdata, reg_wmask);
      end
      if (wr_cmp2) begin
        ch2_compare_q <= merge(ch2_compare_q, reg_wdata, reg_wmask);
      end
      if (wr_mode) begin
        mode_ctrl_q <= merge(mode_ctrl_q, reg_wdata, reg_wmask) & `MODE_MASK;
      end
      if (wr_clksel) begin
        count_clock_select_q <= merge(count_clock_select_q, reg_wdata, reg_wmask);
      end
      if (wr_outctl) begin
        // level bits act once and are never stored
        output_ctrl_q <= outctl_new & `OUT_READ_MASK; // R2
      end
      if (wr_osc) begin
        osc_mode_q <= merge(osc_mode_q, reg_wdata, reg_wmask) & 8'h01;
      end
      if (wr_irqmask) begin
        irq_mask_q <= merge(irq_mask_q, reg_wdata, reg_wmask) & `IRQ_MASK_BITS;
      end
    end
  end

  // ----------------------------------------------------------------------
  // timer output level flip-flops
  // ----------------------------------------------------------------------
  // set and clear written together is a forbidden combination and is ignored
  always @(posedge clock) begin
    if (rst) begin
      ch1_level_q <= 1'b0;
      ch2_level_q <= 1'b0;
    end else if (wr_outctl) begin
      if (outctl_new[`OUT_CH1_LEVEL_SET] && !outctl_new[`OUT_CH1_LEVEL_CLEAR]) begin
        ch1_level_q <= 1'b1;
      end else if (!outctl_new[`OUT_CH1_LEVEL_SET] && outctl_new[`OUT_CH1_LEVEL_CLEAR]) begin
        ch1_level_q <= 1'b0;
      end
      if (outctl_new[`OUT_CH2_LEVEL_SET] && !outctl_new[`OUT_CH2_LEVEL_CLEAR]) begin
        ch2_level_q <= 1'b1;
      end else if (!outctl_new[`OUT_CH2_LEVEL_SET] && outctl_new[`OUT_CH2_LEVEL_CLEAR]) begin
        ch2_level_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status and output
  // ----------------------------------------------------------------------
  // a match in the same cycle as a write-one-to-clear keeps its bit set
  reg [7:0] irq_status_d;

  always @* begin
    irq_status_d = irq_status_q;
    if (wr_status) begin
      irq_status_d = irq_status_d & ~(reg_wdata & reg_wmask);
    end
    if (ch1_match_irq) begin
      irq_status_d[`IRQ_CH1] = 1'b1; // R7
    end
    if (ch2_match_irq) begin
      irq_status_d[`IRQ_CH2] = 1'b1; // R7
    end
  end

  // irq is registered from the next status at the same edge as the status, so it leaves a flip-flop
  always @(posedge clock) begin
    if (rst) begin
      irq_status_q <= 8'h00;
      irq          <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d & `IRQ_MASK_BITS;
      irq          <= |(irq_status_d & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // port 3 pins
  // ----------------------------------------------------------------------
  // pins 1 and 2 carry the level flip-flop ORed with their latch bit when their output is enabled;
  // the pin only drives when its direction bit is 0
  reg [7:0] pin_value_d;

  always @* begin
    pin_value_d = port3_latch_q;
    if (output_ctrl_q[`OUT_CH1_ENABLE]) begin
      pin_value_d[`PIN_CH1_WAVE] = ch1_level_q | port3_latch_q[`PIN_CH1_WAVE];
    end
    if (output_ctrl_q[`OUT_CH2_ENABLE]) begin
      pin_value_d[`PIN_CH2_WAVE] = ch2_level_q | port3_latch_q[`PIN_CH2_WAVE];
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      port3_out  <= 8'h00;
      port3_oe_n <= 8'hFF;
    end else begin
      port3_out  <= pin_value_d;
      port3_oe_n <= port3_direction_q; // R3
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  // reads have no side effect; data stand one cycle after the strobe
  reg [7:0] rdata_d;

  always @* begin
    case (reg_addr)
      `ADDR_PORT3_DIRECTION: rdata_d = port3_direction_q;
      `ADDR_PORT3_LATCH:     rdata_d = port3_latch_q;
      `ADDR_CH1_COUNT:       rdata_d = ch1_count;
      `ADDR_CH2_COUNT:       rdata_d = ch2_count;
      `ADDR_CH1_COMPARE:     rdata_d = ch1_compare_q;
      `ADDR_CH2_COMPARE:     rdata_d = ch2_compare_q;
      `ADDR_MODE_CTRL:       rdata_d = mode_ctrl_q;
      `ADDR_CLOCK_SELECT:    rdata_d = count_clock_select_q;
      `ADDR_OUTPUT_CTRL:     rdata_d = output_ctrl_q & `OUT_READ_MASK; // R2
      `ADDR_OSC_MODE:        rdata_d = osc_mode_q;
      `ADDR_IRQ_STATUS:      rdata_d = irq_status_q;
      `ADDR_IRQ_MASK:        rdata_d = irq_mask_q;
      default:               rdata_d = `READ_UNMAPPED;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: verilog/interval_timer_consts.vh
// register map, field positions, reset values and prescale constants of the dual interval timer
`ifndef INTERVAL_TIMER_CONSTS_VH
`define INTERVAL_TIMER_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the 16-bit register port)
// ----------------------------------------------------------------------
`define ADDR_PORT3_DIRECTION   16'hFF23
`define ADDR_PORT3_LATCH       16'hFF03
`define ADDR_CH1_COUNT         16'hFF40
`define ADDR_CH2_COUNT         16'hFF41
`define ADDR_CH1_COMPARE       16'hFF42
`define ADDR_CH2_COMPARE       16'hFF43
`define ADDR_MODE_CTRL         16'hFF49
`define ADDR_CLOCK_SELECT      16'hFF4E
`define ADDR_OUTPUT_CTRL       16'hFF4F
`define ADDR_OSC_MODE          16'hFFF2
`define ADDR_IRQ_STATUS        16'hFF50
`define ADDR_IRQ_MASK          16'hFF51

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_PORT3_DIRECTION    8'hFF
`define RST_PORT3_LATCH        8'h00
`define RST_COMPARE            8'h00
`define RST_MODE_CTRL          8'h00
`define RST_CLOCK_SELECT       8'h00
`define RST_OUTPUT_CTRL        8'h00
`define RST_OSC_MODE           8'h00
`define RST_IRQ_MASK           8'h00
`define READ_UNMAPPED          8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MODE_CH1_RUN           0
`define MODE_CH2_RUN           1
`define MODE_CASCADE           2
`define MODE_MASK              8'h07
`define OUT_CH1_ENABLE         0
`define OUT_CH1_INVERT         1
`define OUT_CH1_LEVEL_CLEAR    2
`define OUT_CH1_LEVEL_SET      3
`define OUT_CH2_ENABLE         4
`define OUT_CH2_INVERT         5
`define OUT_CH2_LEVEL_CLEAR    6
`define OUT_CH2_LEVEL_SET      7
`define OUT_READ_MASK          8'h33
`define OSC_MODE_BIT           0
`define IRQ_CH1                0
`define IRQ_CH2                1
`define IRQ_MASK_BITS          8'h03
`define PIN_CH1_WAVE           1
`define PIN_CH2_WAVE           2
`define PIN_CH1_EVENT          3
`define PIN_CH2_EVENT          4

// ----------------------------------------------------------------------
// count clock codes and prescale exponents
// ----------------------------------------------------------------------
`define CODE_EVENT_FALL        4'h0
`define CODE_EVENT_RISE        4'h1
`define CODE_FIRST_INTERNAL    4'h6
`define CODE_LONGEST           4'hF
`define CODE_EXP_OFFSET        4'h5
`define EXP_LONGEST            4'hB
`define PRESCALE_W             12
`define PRESCALE_ALL           12'hFFF

`endif

// File: verilog/interval_channel.v
// one 8-bit interval counter channel with its count clock selector
`timescale 1ns/1ps

`include "interval_timer_consts.vh"

module interval_channel #(
  parameter W = 8
) (
  input  wire                    clock,
  input  wire                    rst,
  input  wire                    run,
  input  wire [3:0]              code,
  input  wire                    osc_mode,
  input  wire [`PRESCALE_W-1:0]  prescale_q,
  input  wire                    event_in,
  input  wire [W-1:0]            compare,
  output reg  [W-1:0]            count_q,
  output reg                     match_q
);

  reg                    event_prev_q;
  reg  [3:0]             exp_w;
  reg  [`PRESCALE_W-1:0] span_w;
  reg                    tick_w;

  // ----------------------------------------------------------------------
  // count clock selection
  // ----------------------------------------------------------------------
  // internal period is 2^exp system clocks; osc mode 0 doubles every period
  always @* begin
    if (code == `CODE_LONGEST) begin
      exp_w = `EXP_LONGEST; // R13
    end else begin
      exp_w = code - `CODE_EXP_OFFSET; // R12
    end
    if (!osc_mode) begin
      exp_w = exp_w + 4'h1; // R12 R13
    end
    span_w = ~(`PRESCALE_ALL << exp_w);
    case (code)
      `CODE_EVENT_FALL: tick_w = event_prev_q & ~event_in; // R14
      `CODE_EVENT_RISE: tick_w = ~event_prev_q & event_in; // R14
      default:          tick_w = &(prescale_q | ~span_w);
    endcase
  end

  // ----------------------------------------------------------------------
  // counter: clears on match so the period is (compare + 1) ticks
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      count_q      <= {W{1'b0}};
      match_q      <= 1'b0;
      event_prev_q <= 1'b1; // event pins idle high, so no false edge after reset
    end else begin
      event_prev_q <= event_in;
      match_q      <= 1'b0;
      if (!run) begin
        count_q <= {W{1'b0}}; // R17
      end else if (tick_w) begin
        if (count_q == compare) begin
          count_q <= {W{1'b0}}; // R8 R11
          match_q <= 1'b1; // R7 R8
        end else begin
          count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// File: verification/timer_properties.sv
// concurrent checks on the dual interval timer ports
`timescale 1ns/1ps
module timer_properties (
  input wire        clock,
  input wire        rst,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_wmask,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire [7:0]  port3_in,
  input wire [7:0]  port3_out,
  input wire [7:0]  port3_oe_n,
  input wire        irq
);
  // ----------------------------------------------------------------
  // bus shadows and assertions
  // ----------------------------------------------------------------
  reg  [7:0] mode_q;
  reg  [7:0] cmp1_q;
  reg  [7:0] mask_q;
  wire       dir_wr = reg_wr && reg_addr == 16'hFF23;
  wire [7:0] mask_d = (mask_q & ~reg_wmask) | (reg_wdata & reg_wmask);

  // shadows follow bus writes so the checks need no view inside the block
  always @(posedge clock) begin
    if (rst) begin
      mode_q <= 8'h00;
      cmp1_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 16'hFF49) mode_q <= (mode_q & ~reg_wmask) | (reg_wdata & reg_wmask);
      if (reg_addr == 16'hFF42) cmp1_q <= (cmp1_q & ~reg_wmask) | (reg_wdata & reg_wmask);
      if (reg_addr == 16'hFF51) mask_q <= mask_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_level_bits_zero: assert property (
    reg_rd && reg_addr == 16'hFF4F |=> (reg_rdata & 8'hCC) == 8'h00)
    else $error("level set or clear bit read back as one");
  a_dir_reset_ones: assert property ($fell(rst) |-> port3_oe_n == 8'hFF)
    else $error("pins not all inputs after reset");
  a_dir_write_merge: assert property (dir_wr |-> ##2 port3_oe_n ==
    (($past(port3_oe_n) & ~$past(reg_wmask, 2)) | ($past(reg_wdata, 2) & $past(reg_wmask, 2))))
    else $error("direction write not reflected on output enables");
  a_dir_hold_still: assert property (!$past(dir_wr, 2) |-> $stable(port3_oe_n))
    else $error("output enables moved without a direction write");
  a_stop_count_zero: assert property (
    reg_rd && reg_addr == 16'hFF40 && !mode_q[0] |=> reg_rdata == 8'h00)
    else $error("stopped channel count not zero");
  a_count_within_compare: assert property (
    reg_rd && reg_addr == 16'hFF40 |=> reg_rdata <= cmp1_q)
    else $error("count passed its compare value");
  a_irq_needs_mask: assert property (irq |-> $past(mask_q) != 8'h00)
    else $error("interrupt high with every source masked");
  a_irq_mask_off: assert property (
    reg_wr && reg_addr == 16'hFF51 && (mask_d & 8'h03) == 8'h00 |-> ##2 !irq)
    else $error("interrupt stayed high after masking");

  c_bit_write: cover property (dir_wr && reg_wmask == 8'h02);
  c_irq_rise: cover property ($rose(irq));
  c_ctrl_read: cover property (reg_rd && reg_addr == 16'hFF4F);
endmodule

bind dual_8bit_interval_timer timer_properties timer_properties_i (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wmask(reg_wmask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port3_in(port3_in), .port3_out(port3_out), .port3_oe_n(port3_oe_n), .irq(irq));

// File: verification/port3_partner.sv
// event pins and pin loop-back standing at the timer's port 3
`timescale 1ns/1ps
module port3_partner (
  input  wire       clock,
  input  wire [7:0] port3_out,
  input  wire [7:0] port3_oe_n,
  output wire [7:0] port3_in
);
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  reg [1:0] ev_q;

  // a driven pin reads its own level; an undriven one shows pull-up or event line
  assign port3_in = (port3_out & ~port3_oe_n) | ({3'b111, ev_q, 3'b111} & port3_oe_n);
  initial ev_q = 2'b11;

  // one low-then-high event pulse, three clocks per level so each edge is seen
  task pulse(input [1:0] ch);
    begin
      @(posedge clock);
      ev_q[ch] <= 1'b0;
      repeat (3) @(posedge clock);
      ev_q[ch] <= 1'b1;
      repeat (3) @(posedge clock);
    end
  endtask
endmodule

// File: verification/dual_8bit_interval_timer_tb.sv
// self-checking bench for the dual 8-bit interval timer
`timescale 1ns/1ps
module dual_8bit_interval_timer_tb;
  // ----------------------------------------------------------------
  // stimulus, bus tasks and scenarios
  // ----------------------------------------------------------------
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [15:0] reg_addr = 16'h0000;
  reg  [7:0]  reg_wdata = 8'h00;
  reg  [7:0]  reg_wmask = 8'h00;
  wire [7:0]  reg_rdata, port3_in, port3_out, port3_oe_n;
  wire        irq;
  integer     miscompares = 0, checks_done = 0, cyc = 0, t0, n;
  reg  [1:0]  ch, osc;
  reg  [4:0]  code;
  reg  [7:0]  nn;

  dual_8bit_interval_timer dual_8bit_interval_timer_i (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port3_in(port3_in), .port3_out(port3_out),
    .port3_oe_n(port3_oe_n), .irq(irq));
  port3_partner port3_partner_i (.clock(clock), .port3_out(port3_out),
    .port3_oe_n(port3_oe_n), .port3_in(port3_in));

  // clock and a cycle count for interval measurement
  always #25 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  task chk8(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chkn(input integer got, input integer exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // an idle cycle after each strobe keeps a strobe from being set twice in one step
  task wr(input [15:0] a, input [7:0] d, input [7:0] m);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wmask <= m;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd(input [15:0] a, input [7:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk8(reg_rdata, exp);
      @(posedge clock);
    end
  endtask
  // bounded wait for the interrupt line, sampled once edge updates have landed
  task wirq;
    begin
      n = 0;
      #1;
      while (irq !== 1'b1 && n < 5000) begin
        @(posedge clock);
        #1 n = n + 1;
      end
      // a wait that runs out is a mismatch, not a silent fall-through
      if (irq !== 1'b1) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t irq wait timed out got=%h exp=%h", $time, irq, 1'b1);
      end
    end
  endtask
  // expected interval in clocks: (compare + 1) count periods
  function integer per(input o, input [4:0] c, input [7:0] v);
    per = (v + 1) * ((c == 5'd15) ? 2048 : (1 << (c - 5'd5))) * (o ? 1 : 2);
  endfunction
  task test_done;
    begin
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // watchdog about half again above the roughly 39000 cycles the scenarios need
  initial begin
    repeat (60000) @(posedge clock);
    miscompares = miscompares + 1;
    test_done;
  end

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(16'hFF23, 8'hFF);
    chk8(port3_oe_n, 8'hFF);
    wr(16'hFF23, 8'h5A, 8'hFF);
    rd(16'hFF23, 8'h5A);
    wr(16'hFF23, 8'h00, 8'h02);
    rd(16'hFF23, 8'h58);
    chk8(port3_oe_n, 8'h58);
    wr(16'hFF03, 8'h00, 8'hFF);
    wr(16'hFF4F, 8'h09, 8'hFF);
    rd(16'hFF4F, 8'h01);
    chk8({7'h00, port3_in[1]}, 8'h01);
    wr(16'hFF4F, 8'h05, 8'hFF);
    rd(16'hFF4F, 8'h01);
    chk8({7'h00, port3_out[1]}, 8'h00);
    wr(16'hFF4F, 8'hC0, 8'hFF);
    rd(16'hFF4F, 8'h00);
    wr(16'h1234, 8'hA5, 8'hFF);
    rd(16'h1234, 8'h00);
    // masked source sets status but holds the line low
    wr(16'hFFF2, 8'h01, 8'hFF);
    wr(16'hFF4E, 8'h06, 8'hFF);
    wr(16'hFF42, 8'h01, 8'hFF);
    wr(16'hFF49, 8'h01, 8'hFF);
    repeat (20) @(posedge clock);
    #1 chk8({7'h00, irq}, 8'h00);
    rd(16'hFF50, 8'h01);
    rd(16'hFF41, 8'h00);
    wr(16'hFF51, 8'h01, 8'hFF);
    #1 chk8({7'h00, irq}, 8'h01);
    // masking the only pending source drops the line while status stays set
    wr(16'hFF51, 8'h00, 8'hFF);
    #1 chk8({7'h00, irq}, 8'h00);
    // every internal code, both oscillation modes, both channels
    for (ch = 0; ch < 2; ch = ch + 1)
      for (osc = 0; osc < 2; osc = osc + 1)
        for (code = 6; code < 16; code = code + 1) begin
          nn = (code == 6) ? 8'hFF : ((code < 12) ? 8'h01 : 8'h00);
          wr(16'hFF49, 8'h00, 8'hFF);
          wr(16'hFFF2, {7'h00, osc[0]}, 8'hFF);
          wr(16'hFF4E, {4'h0, code[3:0]} << {ch, 2'b00}, 8'hFF);
          wr(16'hFF42 + ch, nn, 8'hFF);
          wr(16'hFF51, 8'h01 << ch, 8'hFF);
          wr(16'hFF50, 8'h03, 8'hFF);
          wr(16'hFF49, 8'h01 << ch, 8'hFF);
          wirq;
          t0 = cyc;
          wr(16'hFF50, 8'h03, 8'hFF);
          wirq;
          chkn(cyc - t0, per(osc[0], code, nn));
        end
    // event edges, falling and rising, on each channel
    for (ch = 0; ch < 2; ch = ch + 1)
      for (code = 0; code < 2; code = code + 1) begin
        wr(16'hFF49, 8'h00, 8'hFF);
        wr(16'hFF4E, {4'h0, code[3:0]} << {ch, 2'b00}, 8'hFF);
        wr(16'hFF42 + ch, 8'h02, 8'hFF);
        wr(16'hFF51, 8'h01 << ch, 8'hFF);
        wr(16'hFF50, 8'h03, 8'hFF);
        wr(16'hFF49, 8'h01 << ch, 8'hFF);
        port3_partner_i.pulse(ch);
        port3_partner_i.pulse(ch);
        #1 chk8({7'h00, irq}, 8'h00);
        port3_partner_i.pulse(ch);
        repeat (3) @(posedge clock);
        #1 chk8({7'h00, irq}, 8'h01);
      end
    wr(16'hFF49, 8'h00, 8'hFF);
    rd(16'hFF40, 8'h00);
    test_done;
  end
endmodule
